// ==== eep_defines.svh ====
// constants of the two-wire eeprom slave front end
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

// ============================================================
// register map
`define EEP_REG_CTRL     8'h00
`define EEP_REG_STATUS   8'h04
`define EEP_REG_ADDR     8'h08
`define EEP_REG_COUNT    8'h0c

// ============================================================
// fields and reset values
`define EEP_CTRL_EN_BIT  0
`define EEP_CTRL_WP_BIT  1
`define EEP_CTRL_RST     2'h1
// arbitrary value, not tied to any maker
`define EEP_DEV_TYPE_ID  4'h6
`define EEP_ADDR_W       16
`define EEP_PAGE_W       7
`define EEP_SYNC_W       7

`endif

// ==== eep_pkg.sv ====
// types of the two-wire eeprom slave front end
package eep_pkg;
   typedef enum logic [2:0] {
      eep_st_off,
      eep_st_idle,
      eep_st_rx,
      eep_st_ack,
      eep_st_tx,
      eep_st_rack
   } eep_state_t;

   typedef enum logic [1:0] {
      eep_k_devsel,
      eep_k_addr_hi,
      eep_k_addr_lo,
      eep_k_data
   } eep_kind_t;
endpackage

// ==== eep_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module eep_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ==== eep_mem.sv ====
// byte-wide array with registered read data
`timescale 1ns/1ns
module eep_mem #(
   parameter int AW = 16
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic          re,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   // one byte per location, 2**AW locations
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we)
         mem[addr] <= wdata;
      if (re)
         rdata <= mem[addr];
   end
endmodule

// ==== eep_slave.sv ====
// two-wire eeprom slave front end with apb status and control
`timescale 1ns/1ns
`include "eep_defines.svh"
module eep_slave
   import eep_pkg::*;
#(
   parameter int         ADDR_W   = `EEP_ADDR_W,
   parameter int         PAGE_W   = `EEP_PAGE_W,
   parameter logic [3:0] DEV_TYPE = `EEP_DEV_TYPE_ID
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        select_strap_0,
   input  wire logic        select_strap_1,
   input  wire logic        select_strap_2,
   input  wire logic        write_protect_input,
   input  wire logic        por_ok
);
   // ============================================================
   // pin synchronisation
   logic [`EEP_SYNC_W-1:0] pins_s;
   logic                   scl_s;
   logic                   sda_s;
   logic [2:0]             strap_s;
   logic                   wp_s;
   logic                   por_s;

   eep_sync #(.W(`EEP_SYNC_W)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({por_ok, write_protect_input, select_strap_2, select_strap_1,
               select_strap_0, sda_in, scl_in}),
      .q     (pins_s)
   );

   assign scl_s   = pins_s[0];
   assign sda_s   = pins_s[1];
   // pads carry pull-downs, so open straps arrive as zero
   assign strap_s = pins_s[4:2];
   // open write protect arrives low and writes stay allowed
   assign wp_s    = pins_s[5];
   assign por_s   = pins_s[6];

   // ============================================================
   // serial clock and data edges
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic ev_start;
   logic ev_stop;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // the serial clock is the only bit strobe
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign ev_start = scl_s & scl_q & sda_q & ~sda_s;
   assign ev_stop  = scl_s & scl_q & ~sda_q & sda_s;

   // ============================================================
   // control register and effective inputs
   logic [1:0] ctrl;
   logic       active;
   logic       wp_eff;

   // detector low or block disabled: deaf to the bus
   assign active = por_s & ctrl[`EEP_CTRL_EN_BIT];
   assign wp_eff = wp_s | ctrl[`EEP_CTRL_WP_BIT];

   // ============================================================
   // helpers
   function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
      // writes roll over inside the page, upper bits kept
      page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + {{(PAGE_W-1){1'b0}}, 1'b1}};
   endfunction

   function automatic logic [ADDR_W-1:0] lin_inc(input logic [ADDR_W-1:0] a);
      lin_inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
   endfunction

   function automatic logic reg_known(input logic [7:0] a);
      reg_known = (a == `EEP_REG_CTRL) || (a == `EEP_REG_STATUS) ||
                  (a == `EEP_REG_ADDR) || (a == `EEP_REG_COUNT);
   endfunction

   // ============================================================
   // protocol state
   eep_state_t       state;
   eep_kind_t        kind;
   logic [3:0]       bitcnt;
   logic [7:0]       shreg;
   logic [7:0]       txreg;
   logic             ack_pend;
   logic             rw;
   logic             wp_latch;
   logic             more;
   logic [ADDR_W-1:0] addr;
   logic [7:0]       addr_hi;
   logic [7:0]       mem_rdata;
   logic [7:0]       rx_byte;
   logic             ev_byte;
   logic             sel_ok;
   logic             wr_ok;
   logic             mem_we;
   logic             mem_re;
   logic [2:0]       tx_idx;

   // msb first: type, straps, direction bit
   assign rx_byte = {shreg[6:0], sda_s};
   // input data taken on the clock rising edge only
   assign ev_byte = (state == eep_st_rx) && scl_rise && (bitcnt == 4'd7);
   // type code against b7..b4 straps 2,1,0 against b3,b2,b1
   assign sel_ok  = (rx_byte[7:4] == DEV_TYPE) &&
                    (rx_byte[3:1] == {strap_s[2], strap_s[1], strap_s[0]});
   // protect seen from start through the address bytes, or now
   assign wr_ok   = ~(wp_latch | wp_eff);
   assign tx_idx  = 3'(4'd7 - bitcnt);

   assign mem_we = ev_byte && (kind == eep_k_data) && wr_ok;
   assign mem_re = (ev_byte && (kind == eep_k_devsel) && sel_ok && rx_byte[0]) ||
                   ((state == eep_st_rack) && scl_rise && ~sda_s);

   eep_mem #(.AW(ADDR_W)) u_mem (
      .clk   (pclk),
      .we    (mem_we),
      .re    (mem_re),
      .addr  (addr),
      .wdata (rx_byte),
      .rdata (mem_rdata)
   );

   // ============================================================
   // bus sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= eep_st_off;
         kind     <= eep_k_devsel;
         bitcnt   <= 4'h0;
         shreg    <= 8'h00;
         txreg    <= 8'h00;
         ack_pend <= 1'b0;
         rw       <= 1'b0;
         wp_latch <= 1'b0;
         more     <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (!active) begin
         state  <= eep_st_off;
         sda_oe <= 1'b0;
      end else if (state == eep_st_off) begin
         // threshold crossed: clean internal state, then standby
         state    <= eep_st_idle;
         kind     <= eep_k_devsel;
         bitcnt   <= 4'h0;
         ack_pend <= 1'b0;
         rw       <= 1'b0;
         wp_latch <= 1'b0;
         more     <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (ev_start) begin
         // a start restarts any transfer, repeated start included
         state    <= eep_st_rx;
         kind     <= eep_k_devsel;
         bitcnt   <= 4'h0;
         wp_latch <= wp_eff;
         sda_oe   <= 1'b0;
      end else if (ev_stop) begin
         // no self-timed cycle here, so stop always means standby
         state  <= eep_st_idle;
         sda_oe <= 1'b0;
      end else begin
         case (state)
            eep_st_rx: begin
               if (scl_rise) begin
                  shreg  <= rx_byte;
                  bitcnt <= bitcnt + 4'h1;
                  if (kind != eep_k_data)
                     wp_latch <= wp_latch | wp_eff;
               end
               if (ev_byte) begin
                  case (kind)
                     eep_k_devsel: begin
                        ack_pend <= sel_ok;
                        rw       <= rx_byte[0];
                     end
                     eep_k_data: ack_pend <= wr_ok;
                     default:    ack_pend <= 1'b1;
                  endcase
               end
               if (scl_fall && bitcnt == 4'd8) begin
                  if (kind == eep_k_devsel && !ack_pend) begin
                     // no match: drop off the bus until the next start
                     state <= eep_st_idle;
                  end else begin
                     state  <= eep_st_ack;
                     sda_oe <= ack_pend;
                  end
               end
            end
            eep_st_ack: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  if (kind == eep_k_devsel && rw) begin
                     state  <= eep_st_tx;
                     txreg  <= mem_rdata;
                     sda_oe <= ~mem_rdata[7];
                  end else begin
                     state  <= eep_st_rx;
                     sda_oe <= 1'b0;
                     case (kind)
                        eep_k_devsel:  kind <= eep_k_addr_hi;
                        eep_k_addr_hi: kind <= eep_k_addr_lo;
                        default:       kind <= eep_k_data;
                     endcase
                  end
               end
            end
            eep_st_tx: begin
               if (scl_rise)
                  bitcnt <= bitcnt + 4'h1;
               if (scl_fall) begin
                  if (bitcnt == 4'd8) begin
                     // release for the master's acknowledge
                     state  <= eep_st_rack;
                     sda_oe <= 1'b0;
                  end else begin
                     sda_oe <= ~txreg[tx_idx]; // only ever pulls low
                  end
               end
            end
            eep_st_rack: begin
               if (scl_rise)
                  more <= ~sda_s;
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  if (more) begin
                     state  <= eep_st_tx;
                     txreg  <= mem_rdata;
                     sda_oe <= ~mem_rdata[7];
                  end else begin
                     // no-ack ends the read; wait for the stop
                     state  <= eep_st_idle;
                     sda_oe <= 1'b0;
                  end
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ============================================================
   // address counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr    <= '0;
         addr_hi <= 8'h00;
      end else if (active && ev_byte) begin
         case (kind)
            eep_k_addr_hi: addr_hi <= rx_byte;
            eep_k_addr_lo: addr    <= ADDR_W'({addr_hi, rx_byte});
            eep_k_data: begin
               if (wr_ok)
                  addr <= page_inc(addr);
            end
            default: ;
         endcase
      end else if (active && state == eep_st_tx && scl_fall && bitcnt == 4'd8) begin
         // reads run linearly through the whole array
         addr <= lin_inc(addr);
      end
   end

   // open drain: the driven level is always low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sda_o <= 1'b0;
      else
         sda_o <= 1'b0;
   end

   // ============================================================
   // activity counters
   logic [15:0] wr_count;
   logic [15:0] nack_count;
   logic        apb_wr;
   logic        apb_rd;

   assign apb_wr = psel & penable & ~pready & pwrite;
   assign apb_rd = psel & penable & ~pready & ~pwrite;

   // a write to the count register clears both; a same-cycle event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_count   <= 16'h0000;
         nack_count <= 16'h0000;
      end else begin
         if (mem_we)
            wr_count <= wr_count + 16'h0001;
         else if (apb_wr && paddr == `EEP_REG_COUNT)
            wr_count <= 16'h0000;
         if (ev_byte && kind == eep_k_data && !wr_ok)
            nack_count <= nack_count + 16'h0001;
         else if (apb_wr && paddr == `EEP_REG_COUNT)
            nack_count <= 16'h0000;
      end
   end

   // ============================================================
   // apb slave: one wait state, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         ctrl    <= `EEP_CTRL_RST;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && penable && !pready) begin
            pslverr <= ~reg_known(paddr);
            if (apb_wr && paddr == `EEP_REG_CTRL)
               ctrl <= pwdata[1:0];
            if (apb_rd) begin
               case (paddr)
                  `EEP_REG_CTRL:   prdata <= {30'h0, ctrl};
                  `EEP_REG_STATUS: prdata <= {26'h0, wp_eff, por_s, rw, 3'(state)};
                  `EEP_REG_ADDR:   prdata <= 32'(addr);
                  `EEP_REG_COUNT:  prdata <= {nack_count, wr_count};
                  default:         prdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end
endmodule

// ==== eep_slave_assertions.sv ====
// assertion checker for the two-wire eeprom slave front end
`timescale 1ns/1ns
module eep_slave_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_in,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   input wire logic        por_ok
);
   // ============================================================
   // register bus and serial wire relations
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered next cycle");
   AST_APB_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_QUAL: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   AST_DRIVE_CLK_LOW: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data line pulled while clock high");
   AST_RELEASE_CLK_LOW: assert property ($fell(sda_oe) && por_ok |-> !scl_in)
      else $error("data line released while clock high");
   AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
      else $error("pull-down shorter than half a bit");
   AST_POWER_QUIET: assert property (!por_ok [*5] |-> !sda_oe)
      else $error("data line pulled without power");

   cover property (pslverr);
   cover property ($rose(sda_oe));
   cover property ($fell(por_ok));
endmodule

bind eep_slave eep_slave_assertions u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
   .pslverr, .scl_in, .sda_o, .sda_oe, .por_ok);

// ==== eep_i2c_master.sv ====
// behavioural two-wire bus master facing the eeprom front end
`timescale 1ns/1ns
module eep_i2c_master (
   input  wire logic pclk,
   output logic      scl,
   output logic      m_oe,
   input  wire logic sda
);
   // ============================================================
   // bit timing: 16 pclk per serial clock, in quarters of 4
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   task automatic q;
      repeat (4) @(posedge pclk);
   endtask
   // serves as repeated start too: release, raise clock, then pull
   task automatic start;
      m_oe <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      m_oe <= 1'b1;
      q;
      scl <= 1'b0;
      q;
   endtask
   task automatic stop;
      m_oe <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      m_oe <= 1'b0;
      q;
   endtask
   // eight bits then the acknowledge slot; a 1 releases the wire
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         m_oe <= ~tx[i];
         q;
         scl <= 1'b1;
         q;
         rx[i] = sda;
         q;
         scl <= 1'b0;
         q;
      end
   endtask
endmodule

// ==== test_i2c_eeprom_slave_front_end.sv ====
// self-checking bench for the two-wire eeprom slave front end
`timescale 1ns/1ns
`include "eep_defines.svh"
module test_i2c_eeprom_slave_front_end;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        sda_o, sda_oe, scl, m_oe, wp, por_ok, e;
   logic [2:0]  straps;
   wire         sda = ~(sda_oe | m_oe);
   int          fails, n_tests, cyc;

   eep_slave DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .scl_in(scl), .sda_in(sda), .sda_o, .sda_oe, .select_strap_0(straps[0]),
      .select_strap_1(straps[1]), .select_strap_2(straps[2]), .write_protect_input(wp), .por_ok);
   eep_i2c_master MST (.pclk, .scl, .m_oe, .sda);

   // ============================================================
   // compare, report and bus helpers
   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk_w(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         fails++;
         $display("unexpected at %0t: word %h, want %h", $time, g, x);
      end
   endtask
   task automatic chk_b(input logic g, input logic x);
      n_tests++;
      if (g !== x) begin
         fails++;
         $display("unexpected at %0t: bit %b, want %b", $time, g, x);
      end
   endtask
   // waits for ready; no fixed answer time is assumed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      // one edge between calls, so no signal is assigned twice in a step
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         fails++;
         $display("unexpected at %0t: no ready", $time);
      end
   endtask
   function automatic logic [7:0] sel(input logic rw);
      return {`EEP_DEV_TYPE_ID, straps, rw};
   endfunction
   // one byte from the master; x is the expected level in the ack slot
   task automatic send(input logic [7:0] b, input logic x);
      logic [8:0] rx;
      MST.xfer({b, 1'b1}, rx);
      chk_b(rx[0], x);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic x);
      MST.start;
      send(sel(1'b0), 1'b0);
      send(a[15:8], 1'b0);
      send(a[7:0], 1'b0);
      send(d, x);
      MST.stop;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      logic [8:0] rx;
      MST.start;
      send(sel(1'b0), 1'b0);
      send(a[15:8], 1'b0);
      send(a[7:0], 1'b0);
      MST.start;
      send(sel(1'b1), 1'b0);
      MST.xfer(9'h1ff, rx);
      chk_w({24'h0, rx[8:1]}, {24'h0, x});
      MST.stop;
   endtask

   // ============================================================
   // scenarios
   task automatic t_regs;
      apb(1'b0, `EEP_REG_CTRL, 32'h0);
      chk_w(r, 32'h1);
      chk_b(e, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk_w(r, 32'h0);
      chk_b(e, 1'b1);
   endtask
   task automatic t_dead;
      MST.start;
      send(sel(1'b0), 1'b1);
      MST.stop;
   endtask
   task automatic t_rw;
      wr(16'h8a7f, 8'h3c, 1'b0);
      wr(16'h0180, 8'hc3, 1'b0);
      rd(16'h8a7f, 8'h3c);
      rd(16'h0180, 8'hc3);
   endtask
   // two-byte write, then a read whose first byte the master acknowledges
   task automatic t_seq;
      logic [8:0] rx;
      MST.start;
      send(sel(1'b0), 1'b0);
      send(8'h00, 1'b0);
      send(8'h10, 1'b0);
      send(8'ha5, 1'b0);
      send(8'h96, 1'b0);
      MST.stop;
      rd(16'h0011, 8'h96);
      MST.start;
      send(sel(1'b0), 1'b0);
      send(8'h00, 1'b0);
      send(8'h10, 1'b0);
      MST.start;
      send(sel(1'b1), 1'b0);
      MST.xfer(9'h1fe, rx);
      chk_w({24'h0, rx[8:1]}, 32'h0000_00a5);
      MST.xfer(9'h1ff, rx);
      chk_w({24'h0, rx[8:1]}, 32'h0000_0096);
      chk_b(rx[0], 1'b1);
      MST.stop;
      apb(1'b0, `EEP_REG_ADDR, 32'h0);
      chk_w(r, 32'h0000_0012);
      apb(1'b0, `EEP_REG_STATUS, 32'h0);
      chk_w(r, 32'h0000_0019);
   endtask
   // one wrong strap bit at a time, then a wrong type code
   task automatic t_straps;
      for (int i = 1; i <= 4; i++) begin
         MST.start;
         send(sel(1'b0) ^ (8'h01 << (i < 4 ? i : 7)), 1'b1);
         MST.stop;
      end
      straps <= 3'b000;
      wr(16'h0002, 8'h5a, 1'b0);
      rd(16'h0002, 8'h5a);
      straps <= 3'b101;
   endtask
   task automatic t_protect;
      wp <= 1'b1;
      wr(16'h8a7f, 8'h55, 1'b1);
      wp <= 1'b0;
      apb(1'b1, `EEP_REG_CTRL, 32'h3);
      wr(16'h0180, 8'h66, 1'b1);
      apb(1'b1, `EEP_REG_CTRL, 32'h1);
      rd(16'h8a7f, 8'h3c);
      rd(16'h0180, 8'hc3);
      // five bytes written so far, two data bytes refused
      apb(1'b0, `EEP_REG_COUNT, 32'h0);
      chk_w(r, 32'h0002_0005);
      apb(1'b1, `EEP_REG_COUNT, 32'h0);
      apb(1'b0, `EEP_REG_COUNT, 32'h0);
      chk_w(r, 32'h0000_0000);
   endtask

   // ============================================================
   // clock, watchdog and main sequence
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         print_verdict;
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wp = 1'b0;
      por_ok = 1'b0;
      straps = 3'b101;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_dead;
      por_ok <= 1'b1;
      repeat (20) @(posedge pclk);
      t_rw;
      t_seq;
      t_straps;
      t_protect;
      por_ok <= 1'b0;
      repeat (20) @(posedge pclk);
      t_dead;
      print_verdict;
   end
endmodule
